//--- hw/sys_status_consts.svh
// Purpose: Offsets, field positions and reset values of the status/control port block
// Assumes: Included by bare name from the design files
// Notes: Register positions are word indices; byte address is four times the index
`ifndef SYS_STATUS_CONSTS_SVH
`define SYS_STATUS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SSP_PORT_INDEX 8'h61
`define SSP_NMI_INDEX 8'h62

// ----------------------------------------------------------------
// Port field positions
// ----------------------------------------------------------------
`define SSP_BIT_PAR_ERR 7
`define SSP_BIT_IOCHK 6
`define SSP_BIT_T2_OUT 5
`define SSP_BIT_REFRESH 4
`define SSP_BIT_IOCHK_DIS 3
`define SSP_BIT_PAR_DIS 2
`define SSP_BIT_SPK_DATA 1
`define SSP_BIT_T2_GATE 0

// ----------------------------------------------------------------
// Software NMI register field positions
// ----------------------------------------------------------------
`define SSP_BIT_SW_NMI 0
`define SSP_BIT_NMI_STATE 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSP_CTRL_RST 4'h0
`define SSP_SW_NMI_RST 1'b0

`endif

//--- hw/sys_status_pkg.sv
// Purpose: Shared types of the status/control port block
// Assumes: Nothing beyond the language
// Notes: Constants live in sys_status_consts.svh
`default_nettype none

package sys_status_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

  typedef enum logic [0:0] {
    CH_IDLE = 1'b0,
    CH_RESP = 1'b1
  } chan_state_t;

endpackage

`default_nettype wire

//--- hw/parity_error_latch.sv
// Purpose: Holds the memory parity error seen at the end of a local memory read
// Assumes: Read strobe and error flag come from logic on the same clock
// Notes: Latch changes only on a completed read
`default_nettype none

module parity_error_latch (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory read completion
  input wire logic rd_done,
  input wire logic rd_par_err,
  // Latched error
  output logic par_err_r
);

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  // Error shows one clock after the read ends, then holds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_err_r <= 1'b0;
    end else if (rd_done) begin
      par_err_r <= rd_par_err;
    end
  end

endmodule

`default_nettype wire

//--- hw/system_status_port.sv
// Purpose: Legacy system status/control port with NMI generation, reached over AXI4-Lite
// Assumes: Channel check, timer 2 output and refresh toggle arrive from pins
// Notes: Port sits at word index 61h; software NMI control at index 62h
//
// Contract
// - Memory parity error raises NMI toward the processor.
// - Software can raise NMI independent of error detection.
// - Port at index 61h is decoded; its eight bits are read, and only bits 3..0 are written.
// - Bits 7..4 read status: parity, channel check, timer 2, refresh; writes ignored.
// - Bit 3 at 0 enables channel check, at 1 disables it.
// - Bit 2 at 0 enables parity check, at 1 disables it.
// - Bit 1 is stored and drives speaker data.
// - Bit 0 is stored and drives the timer 2 gate.
// - Latched parity error holds until a later clean memory read clears it.
`default_nettype none

`include "sys_status_consts.svh"

module system_status_port #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Local memory read completion
  input wire logic mem_rd_done,
  input wire logic mem_rd_par_err,
  // Pins from the board
  input wire logic io_chan_chk,
  input wire logic timer2_out,
  input wire logic refresh_tgl,
  // Outputs to the board and processor
  output logic nmi,
  output logic speaker_data,
  output logic timer2_gate,
  output logic io_chk_disable,
  output logic par_chk_disable
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Both registers need byte address bits up to 0x188
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 9 and 32");
  end

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_ADDR = ADDR_W'({`SSP_PORT_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] NMI_ADDR = ADDR_W'({`SSP_NMI_INDEX, 2'b00});

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_sync_r;

  assign pin_in = {refresh_tgl, timer2_out, io_chan_chk};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_meta_r[i] <= 1'b0;
        pin_sync_r[i] <= 1'b0;
      end else begin
        pin_meta_r[i] <= pin_in[i];
        pin_sync_r[i] <= pin_meta_r[i];
      end
    end
  end

  logic iochk_s;
  logic t2_out_s;
  logic refresh_s;
  assign iochk_s = pin_sync_r[0];
  assign t2_out_s = pin_sync_r[1];
  assign refresh_s = pin_sync_r[2];

  // ----------------------------------------------------------------
  // Parity error latch
  // ----------------------------------------------------------------
  logic par_err;

  parity_error_latch u_par_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .rd_done(mem_rd_done),
    .rd_par_err(mem_rd_par_err),
    .par_err_r(par_err)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  sys_status_pkg::chan_state_t wr_state_r;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic aw_take;
  logic w_take;
  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_port;
  logic wr_nmi;

  // Channels are held until both have arrived; response follows both
  assign s_axi_awready = !aw_held_r && (wr_state_r == sys_status_pkg::CH_IDLE);
  assign s_axi_wready = !w_held_r && (wr_state_r == sys_status_pkg::CH_IDLE);
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign aw_have = aw_held_r || aw_take;
  assign w_have = w_held_r || w_take;
  assign wr_fire = aw_have && w_have && (wr_state_r == sys_status_pkg::CH_IDLE);
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_port = wr_fire && (wr_addr == PORT_ADDR) && wr_strb[0];
  assign wr_nmi = wr_fire && (wr_addr == NMI_ADDR) && wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= sys_status_pkg::CH_IDLE;
      bresp_r <= sys_status_pkg::RESP_OKAY;
    end else begin
      unique case (wr_state_r)
        sys_status_pkg::CH_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= sys_status_pkg::CH_RESP;
            bresp_r <= (wr_addr == PORT_ADDR || wr_addr == NMI_ADDR) ?
                       sys_status_pkg::RESP_OKAY : sys_status_pkg::RESP_SLVERR;
          end
        end
        sys_status_pkg::CH_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= sys_status_pkg::CH_IDLE;
          end
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_r == sys_status_pkg::CH_RESP);
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // Only bits 3..0 are stored; status bits take no write
  logic [3:0] ctrl_r;
  logic sw_nmi_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SSP_CTRL_RST;
    end else if (wr_port) begin
      ctrl_r <= wr_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_nmi_r <= `SSP_SW_NMI_RST;
    end else if (wr_nmi) begin
      sw_nmi_r <= wr_data[`SSP_BIT_SW_NMI];
    end
  end

  assign io_chk_disable = ctrl_r[`SSP_BIT_IOCHK_DIS];
  assign par_chk_disable = ctrl_r[`SSP_BIT_PAR_DIS];
  assign speaker_data = ctrl_r[`SSP_BIT_SPK_DATA];
  assign timer2_gate = ctrl_r[`SSP_BIT_T2_GATE];

  // ----------------------------------------------------------------
  // Status and NMI
  // ----------------------------------------------------------------
  logic iochk_seen;
  logic par_nmi;
  logic nmi_r;
  logic [7:0] port_val;

  // Channel check is reported only while its check is enabled
  assign iochk_seen = iochk_s && !ctrl_r[`SSP_BIT_IOCHK_DIS];
  assign par_nmi = par_err && !ctrl_r[`SSP_BIT_PAR_DIS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= par_nmi || iochk_seen || sw_nmi_r;
    end
  end

  assign nmi = nmi_r;

  assign port_val = {par_err, iochk_seen, t2_out_s, refresh_s, ctrl_r};

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  sys_status_pkg::chan_state_t rd_state_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;

  assign s_axi_arready = (rd_state_r == sys_status_pkg::CH_IDLE);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= sys_status_pkg::CH_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sys_status_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state_r)
        sys_status_pkg::CH_IDLE: begin
          if (ar_take) begin
            rd_state_r <= sys_status_pkg::CH_RESP;
            rresp_r <= sys_status_pkg::RESP_OKAY;
            if (s_axi_araddr == PORT_ADDR) begin
              rdata_r <= {24'h00_0000, port_val};
            end else if (s_axi_araddr == NMI_ADDR) begin
              rdata_r <= {30'h0000_0000, nmi_r, sw_nmi_r};
            end else begin
              rdata_r <= 32'h0000_0000;
              rresp_r <= sys_status_pkg::RESP_SLVERR;
            end
          end
        end
        sys_status_pkg::CH_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= sys_status_pkg::CH_IDLE;
          end
        end
      endcase
    end
  end

  assign s_axi_rvalid = (rd_state_r == sys_status_pkg::CH_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

`default_nettype wire

//--- tb/sys_status_checker_assertions.sv
// Purpose: Port assertions for the status/control port
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module
`default_nettype none
module sys_status_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Board side
  input wire logic mem_rd_done,
  input wire logic mem_rd_par_err,
  input wire logic io_chan_chk,
  input wire logic nmi,
  input wire logic speaker_data,
  input wire logic timer2_gate,
  input wire logic io_chk_disable,
  input wire logic par_chk_disable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_par_nmi: assert property (
    mem_rd_done && mem_rd_par_err && !par_chk_disable |-> ##2 nmi)
    else $error("no nmi on parity error");
  a_chk_nmi: assert property (
    io_chan_chk && !io_chk_disable |-> ##3 nmi)
    else $error("no nmi on channel check");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rd_close: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  a_spk_gate: assert property (
    !$rose(s_axi_bvalid) |-> $stable(speaker_data) && $stable(timer2_gate))
    else $error("speaker or gate moved without write");
  a_chk_bits: assert property (
    !$rose(s_axi_bvalid) |-> $stable(io_chk_disable) && $stable(par_chk_disable))
    else $error("check disables moved without write");
endmodule
bind system_status_port sys_status_checker chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .mem_rd_done, .mem_rd_par_err,
  .io_chan_chk, .nmi, .speaker_data, .timer2_gate, .io_chk_disable,
  .par_chk_disable
);
`default_nettype wire

//--- tb/cpu_core_model.sv
// Purpose: Processor side: ends memory reads, counts NMI entries
// Assumes: Bench pulses rd_go for one cycle
// Notes: Error line toggles between reads so stale values never pass
`default_nettype none
module cpu_core_model (
  // Clock
  input wire logic aclk,
  // Bench commands
  input wire logic rd_go,
  input wire logic rd_bad,
  // Device side
  input wire logic nmi,
  output logic mem_rd_done,
  output logic mem_rd_par_err,
  output int nmi_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nmi_q;
  initial begin
    mem_rd_done = 1'b0;
    mem_rd_par_err = 1'b0;
    nmi_q = 1'b0;
    nmi_rises = 0;
  end
  always @(posedge aclk) begin
    mem_rd_done <= rd_go;
    mem_rd_par_err <= rd_go ? rd_bad : !mem_rd_par_err;
    nmi_q <= nmi;
    if (nmi && !nmi_q) nmi_rises <= nmi_rises + 1;
  end
endmodule
`default_nettype wire

//--- tb/system_status_port_and_nmi_test.sv
// Purpose: Self-checking bench for the status/control port
// Assumes: Default address width
// Notes: Handshakes judged at the falling edge to avoid edge races
`default_nettype none
`include "sys_status_consts.svh"
module system_status_port_and_nmi_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] PA = 12'(4 * `SSP_PORT_INDEX);
  localparam logic [11:0] NA = 12'(4 * `SSP_NMI_INDEX);
  localparam logic [31:0] Z = 32'h0000_0000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = Z, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rd_go = 1'b0, rd_bad = 1'b0;
  logic io_chan_chk = 1'b0, timer2_out = 1'b0, refresh_tgl = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic nmi, speaker_data, timer2_gate, io_chk_disable, par_chk_disable;
  logic mem_rd_done, mem_rd_par_err;
  int error_cnt = 0, comparisons = 0, nmi_rises;
  always #2 aclk = ~aclk;
  system_status_port uut (.*);
  cpu_core_model cpu (.aclk, .rd_go, .rd_bad, .nmi, .mem_rd_done,
    .mem_rd_par_err, .nmi_rises);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er, input logic [31:0] ed);
    logic ah, wh, rh;
    logic [1:0] rs;
    logic [31:0] rd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      wh = s_axi_wvalid & s_axi_wready;
      rh = w ? s_axi_bvalid : s_axi_rvalid;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid & !ah;
      s_axi_arvalid <= s_axi_arvalid & !ah;
      s_axi_wvalid <= s_axi_wvalid & !wh;
      s_axi_bready <= s_axi_bready & !rh;
      s_axi_rready <= s_axi_rready & !rh;
    end
    chk("resp", 32'(er), 32'(rs));
    if (!w) chk("rdata", ed, rd);
  endtask
  task automatic mem_rd(input logic bad);
    @(posedge aclk);
    rd_go <= 1'b1;
    rd_bad <= bad;
    @(posedge aclk);
    rd_go <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ctrl;
    bus(0, PA, Z, 2'b00, Z);
    bus(1, PA, 32'hffff_ffff, 2'b00, Z);
    bus(0, PA, Z, 2'b00, 32'h0000_000f);
    chk("ctl", 32'h0000_000f, {io_chk_disable, par_chk_disable, speaker_data, timer2_gate});
    bus(1, PA, 32'h0000_0005, 2'b00, Z);
    bus(0, PA, Z, 2'b00, 32'h0000_0005);
    chk("ctl", 32'h0000_0005, {io_chk_disable, par_chk_disable, speaker_data, timer2_gate});
    bus(1, PA, Z, 2'b00, Z);
    $display("t_ctrl done");
  endtask
  task automatic t_par;
    mem_rd(1'b1);
    chk("nmi", 1, nmi);
    bus(0, PA, Z, 2'b00, 32'h0000_0080);
    mem_rd(1'b0);
    chk("nmi", 0, nmi);
    bus(1, PA, 32'h0000_0004, 2'b00, Z);
    mem_rd(1'b1);
    chk("nmi", 0, nmi);
    bus(0, PA, Z, 2'b00, 32'h0000_0084);
    mem_rd(1'b0);
    bus(1, PA, Z, 2'b00, Z);
    $display("t_par done");
  endtask
  task automatic t_chk;
    io_chan_chk <= 1'b1;
    timer2_out <= 1'b1;
    refresh_tgl <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("nmi", 1, nmi);
    bus(0, PA, Z, 2'b00, 32'h0000_0070);
    io_chan_chk <= 1'b0;
    bus(1, PA, 32'h0000_0008, 2'b00, Z);
    io_chan_chk <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("nmi", 0, nmi);
    bus(0, PA, Z, 2'b00, 32'h0000_0038);
    io_chan_chk <= 1'b0;
    repeat (4) @(posedge aclk);
    bus(1, PA, Z, 2'b00, Z);
    $display("t_chk done");
  endtask
  task automatic t_sw;
    bus(1, NA, 32'h0000_0001, 2'b00, Z);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("nmi", 1, nmi);
    bus(0, NA, Z, 2'b00, 32'h0000_0003);
    bus(1, NA, Z, 2'b00, Z);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("nmi", 0, nmi);
    bus(1, 12'h100, 32'hffff_ffff, 2'b10, Z);
    bus(0, 12'h100, Z, 2'b10, Z);
    chk("rises", 3, nmi_rises);
    $display("t_sw done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_ctrl;
    t_par;
    t_chk;
    t_sw;
    test_done;
  end
  // Far beyond the hundred or so cycles the scenarios need
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
